/* src/irq_bank_pkg.sv */
// Constants and carrier types for the peripheral interrupt enable/flag bank
package irq_bank_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SRC_N  = 8;

	// Register byte addresses on the bus
	localparam logic [ADDR_W-1:0] OFF_CORE_CTRL = 8'h88;
	localparam logic [ADDR_W-1:0] OFF_ENABLE    = 8'h8c;
	localparam logic [ADDR_W-1:0] OFF_FLAGS     = 8'h90;

	// Reset values
	localparam logic [SRC_N-1:0] RST_CORE_CTRL = 8'h00;
	localparam logic [SRC_N-1:0] RST_ENABLE    = 8'h00;
	localparam logic [SRC_N-1:0] RST_FLAGS     = 8'h00;

	// Core interrupt control bit positions
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_GROUP_EN  = 6;

	// Source bit positions, shared by enable and flag registers
	localparam int BIT_PAR_SLAVE = 7;
	localparam int BIT_ADC_DONE  = 6;
	localparam int BIT_SER_RX    = 5;
	localparam int BIT_SER_TX    = 4;
	localparam int BIT_SYNC_SER  = 3;
	localparam int BIT_CAPCOMP   = 2;
	localparam int BIT_TMR2      = 1;
	localparam int BIT_TMR1      = 0;

	// Flags latched by events; the others mirror a buffer level
	localparam logic [SRC_N-1:0] LATCHED_MASK = 8'hcf;
	localparam logic [SRC_N-1:0] CORE_CTRL_MASK = 8'hc0;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [ADDR_W-1:0] adr;
		logic [3:0]        sel;
		logic [DATA_W-1:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic              ack;
		logic [DATA_W-1:0] dat;
	} wb_rsp_s;

endpackage

/* src/irq_flag_cell.sv */
// One sticky interrupt flag: set by an event, cleared by software, set wins
`timescale 1ns/10ps
`default_nettype none
module irq_flag_cell
(
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);

	logic flag_r;
	logic flag_nxt;

	always_comb
	begin
		flag_nxt = i_set | (flag_r & ~i_clr);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			flag_r <= 1'b0;
		else
			flag_r <= flag_nxt;
	end

	assign o_flag = flag_r;

endmodule
`default_nettype wire

/* src/periph_irq_bank.sv */
// Peripheral interrupt enable and flag bank with a classic Wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
`default_nettype none
module periph_irq_bank
#(
	parameter int HAS_PAR_SLAVE = 1
)
(
	input  wire logic                                 i_core_clk,
	input  wire logic                                 i_rst_n,
	input  wire irq_bank_pkg::wb_req_s                i_wb,
	output irq_bank_pkg::wb_rsp_s                     o_wb,
	input  wire logic [irq_bank_pkg::SRC_N-1:0]       i_src_evt,
	input  wire logic                                 i_rx_buf_full,
	input  wire logic                                 i_tx_buf_empty,
	output logic                                      o_periph_irq
);
	import irq_bank_pkg::*;

	// Elaboration checks on the parameter and the package constants
	generate
		if (HAS_PAR_SLAVE != 0 && HAS_PAR_SLAVE != 1)
		begin : g_chk
			$error("HAS_PAR_SLAVE must be 0 or 1");
		end
		if (SRC_N != 8)
		begin : g_chk_width
			$error("The bank serves exactly eight sources");
		end
		if (DATA_W < SRC_N)
		begin : g_chk_data
			$error("Bus data is narrower than one register");
		end
		if (ADDR_W < 8)
		begin : g_chk_addr
			$error("Bus address too narrow for the register map");
		end
		if (OFF_CORE_CTRL == OFF_ENABLE || OFF_CORE_CTRL == OFF_FLAGS
			|| OFF_ENABLE == OFF_FLAGS)
		begin : g_chk_map
			$error("Register offsets overlap");
		end
		if (LATCHED_MASK[BIT_SER_RX] || LATCHED_MASK[BIT_SER_TX])
		begin : g_chk_mirror
			$error("Buffer-level flags must not be latched");
		end
		if (CORE_CTRL_MASK != ((8'h01 << BIT_GLOBAL_EN) | (8'h01 << BIT_GROUP_EN)))
		begin : g_chk_ctrl
			$error("Core control mask must hold only the two enables");
		end
	endgenerate

	// Reset release through two flip-flops
	logic rst_meta_r;
	logic rst_meta_nxt;
	logic rst_sync_r;
	logic rst_sync_nxt;
	logic rst_n;

	always_comb
	begin
		rst_meta_nxt = 1'b1;
		rst_sync_nxt = rst_meta_r;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= rst_meta_nxt;
			rst_sync_r <= rst_sync_nxt;
		end
	end

	assign rst_n = rst_sync_r;

	// Bus decode
	logic              req;
	logic              wr_commit;
	logic              hit_core;
	logic              hit_enable;
	logic              hit_flags;
	logic [SRC_N-1:0]  wr_byte;

	logic              ack_r;
	logic              ack_nxt;
	logic [DATA_W-1:0] rdat_r;
	logic [DATA_W-1:0] rdat_nxt;
	logic [SRC_N-1:0]  core_ctrl_r;
	logic [SRC_N-1:0]  core_ctrl_nxt;
	logic [SRC_N-1:0]  enable_r;
	logic [SRC_N-1:0]  enable_nxt;

	logic [SRC_N-1:0]  latched;
	logic [SRC_N-1:0]  flag_view;
	logic [SRC_N-1:0]  evt_set;
	logic [SRC_N-1:0]  flag_clr;
	logic [SRC_N-1:0]  pending;

	assign req        = i_wb.cyc & i_wb.stb;
	assign wr_commit  = req & i_wb.we & ack_r & i_wb.sel[0];
	assign hit_core   = (i_wb.adr == OFF_CORE_CTRL);
	assign hit_enable = (i_wb.adr == OFF_ENABLE);
	assign hit_flags  = (i_wb.adr == OFF_FLAGS);
	assign wr_byte    = i_wb.dat[SRC_N-1:0];

	// Register writes take effect at the edge that samples ack high
	always_comb
	begin
		core_ctrl_nxt = core_ctrl_r;
		enable_nxt    = enable_r;
		if (wr_commit && hit_core)
			core_ctrl_nxt = wr_byte & CORE_CTRL_MASK;
		if (wr_commit && hit_enable)
			enable_nxt = wr_byte;
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_ctrl_r <= RST_CORE_CTRL;
			enable_r    <= RST_ENABLE;
		end
		else
		begin
			core_ctrl_r <= core_ctrl_nxt;
			enable_r    <= enable_nxt;
		end
	end

	// Latched flags: event sets, write of one clears, set wins
	always_comb
	begin
		evt_set  = i_src_evt & LATCHED_MASK;
		if (HAS_PAR_SLAVE == 0)
			evt_set[BIT_PAR_SLAVE] = 1'b0;
		flag_clr = (wr_commit && hit_flags) ? (wr_byte & LATCHED_MASK) : '0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < SRC_N; gi++)
		begin : g_flag
			if (LATCHED_MASK[gi])
			begin : g_latched
				irq_flag_cell u_cell
				(
					.i_core_clk (i_core_clk),
					.i_rst_n    (rst_n),
					.i_set      (evt_set[gi]),
					.i_clr      (flag_clr[gi]),
					.o_flag     (latched[gi])
				);
			end
			else
			begin : g_level
				assign latched[gi] = 1'b0;
			end
		end
	endgenerate

	// Read-only flags mirror buffer state
	always_comb
	begin
		flag_view              = latched;
		flag_view[BIT_SER_RX]  = i_rx_buf_full;
		flag_view[BIT_SER_TX]  = i_tx_buf_empty;
	end

	// Ack one cycle after request; unmapped reads return zero
	always_comb
	begin
		ack_nxt  = req & ~ack_r;
		rdat_nxt = rdat_r;
		if (ack_nxt)
		begin
			rdat_nxt = '0;
			if (hit_core)
				rdat_nxt[SRC_N-1:0] = core_ctrl_r;
			else if (hit_enable)
				rdat_nxt[SRC_N-1:0] = enable_r;
			else if (hit_flags)
				rdat_nxt[SRC_N-1:0] = flag_view;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end
		else
		begin
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign o_wb.ack = ack_r;
	assign o_wb.dat = rdat_r;

	// Peripheral request to the CPU
	always_comb
	begin
		pending      = flag_view & enable_r;
		o_periph_irq = (|pending)
			& core_ctrl_r[BIT_GROUP_EN]
			& core_ctrl_r[BIT_GLOBAL_EN];
	end

endmodule
`default_nettype wire

/* testbench/periph_src_model.sv */
// Model of the peripheral sources feeding the flag bank
`timescale 1ns/10ps
`default_nettype none
module periph_src_model
(
	input  wire logic       i_core_clk,
	output logic [7:0]      o_evt,
	output logic            o_rx_full,
	output logic            o_tx_empty
);
	initial
	begin
		o_evt      = 8'h00;
		o_rx_full  = 1'h0;
		o_tx_empty = 1'h1;
	end
	// One-cycle event pulse on the chosen sources
	task automatic fire(input logic [7:0] m);
		@(posedge i_core_clk);
		o_evt <= m;
		@(posedge i_core_clk);
		o_evt <= 8'h00;
	endtask
	// Serial buffer levels
	task automatic bufs(input logic rx, input logic tx);
		@(posedge i_core_clk);
		o_rx_full  <= rx;
		o_tx_empty <= tx;
	endtask
endmodule
`default_nettype wire

/* testbench/periph_irq_bank_chk.sv */
// Port checker for the peripheral interrupt bank
`timescale 1ns/10ps
`default_nettype none
module periph_irq_bank_chk
(
	input wire logic                           i_core_clk,
	input wire logic                           i_rst_n,
	input wire irq_bank_pkg::wb_req_s          i_wb,
	input wire irq_bank_pkg::wb_rsp_s          o_wb,
	input wire logic [irq_bank_pkg::SRC_N-1:0] i_src_evt,
	input wire logic                           i_rx_buf_full,
	input wire logic                           i_tx_buf_empty,
	input wire logic                           o_periph_irq
);
	import irq_bank_pkg::*;
	logic [7:0] ctl_r;
	logic [7:0] en_r;
	wire        wr = o_wb.ack && i_wb.we && i_wb.sel[0];
	wire        rd = o_wb.ack && !i_wb.we;
	// Shadow copies of control and enable
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctl_r <= 8'h00;
			en_r  <= 8'h00;
		end
		else if (wr && i_wb.adr == OFF_CORE_CTRL)
			ctl_r <= i_wb.dat[7:0] & CORE_CTRL_MASK;
		else if (wr && i_wb.adr == OFF_ENABLE)
			en_r <= i_wb.dat[7:0];
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_ack_follows: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack)
		else $error("ack missing");
	a_ack_single: assert property (o_wb.ack |=> !o_wb.ack)
		else $error("ack too long");
	a_upper_zero: assert property (o_wb.ack |-> o_wb.dat[31:8] == 24'h0)
		else $error("upper data set");
	a_en_readback: assert property (rd && i_wb.adr == OFF_ENABLE |-> o_wb.dat[7:0] == $past(en_r))
		else $error("enable readback");
	a_tx_mirror: assert property (rd && i_wb.adr == OFF_FLAGS |-> o_wb.dat[4] == $past(i_tx_buf_empty))
		else $error("tx flag");
	a_rx_mirror: assert property (rd && i_wb.adr == OFF_FLAGS |-> o_wb.dat[5] == $past(i_rx_buf_full))
		else $error("rx flag");
	a_group_gate: assert property (o_periph_irq |-> ctl_r[6] && ctl_r[7])
		else $error("irq not gated");
	a_enable_gate: assert property (o_periph_irq |-> en_r != 8'h00)
		else $error("irq without enable");
	a_irq_raise: assert property (i_src_evt[0] && en_r[0] && ctl_r == 8'hc0 && !wr |=> o_periph_irq)
		else $error("irq not raised");
	cover property (o_periph_irq);
	cover property (rd && i_wb.adr == OFF_FLAGS);
	cover property (wr && i_wb.adr == OFF_ENABLE);
endmodule
bind periph_irq_bank periph_irq_bank_chk chk (.i_core_clk, .i_rst_n, .i_wb, .o_wb, .i_src_evt,
	.i_rx_buf_full, .i_tx_buf_empty, .o_periph_irq);
`default_nettype wire

/* testbench/periph_irq_bank_test.sv */
// Testbench for the peripheral interrupt bank
`timescale 1ns/10ps
`default_nettype none
module periph_irq_bank_test;
	import irq_bank_pkg::*;
	logic       clk = 1'h0;
	logic       rst_n = 1'h0;
	wb_req_s    req = '0;
	wb_rsp_s    rsp;
	logic [7:0] evt;
	logic [7:0] q;
	logic       rx_full;
	logic       tx_empty;
	logic       irq;
	int         errors = 0;
	int         checks_done = 0;
	always #20 clk = ~clk;
	periph_src_model src (.i_core_clk(clk), .o_evt(evt), .o_rx_full(rx_full), .o_tx_empty(tx_empty));
	periph_irq_bank #(.HAS_PAR_SLAVE(1)) uut
		(.i_core_clk(clk), .i_rst_n(rst_n), .i_wb(req), .o_wb(rsp), .i_src_evt(evt),
		.i_rx_buf_full(rx_full), .i_tx_buf_empty(tx_empty), .o_periph_irq(irq));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done = checks_done + 1;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			errors = errors + 1;
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
		do @(posedge clk); while (rsp.ack !== 1'h1);
		q = rsp.dat[7:0];
		req <= '0;
		@(negedge clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors = errors + 1;
		wrap_up();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		wb(1'h0, OFF_ENABLE, 8'h00);
		chk("enable", q, RST_ENABLE);
		wb(1'h0, OFF_FLAGS, 8'h00);
		chk("flags", q, 8'h10);
		wb(1'h1, OFF_CORE_CTRL, 8'hff);
		wb(1'h0, OFF_CORE_CTRL, 8'h00);
		chk("core", q, CORE_CTRL_MASK);
		chk("irq", {7'h0, irq}, 8'h00);
		wb(1'h1, OFF_CORE_CTRL, 8'h00);
		wb(1'h1, OFF_ENABLE, 8'ha5);
		wb(1'h0, OFF_ENABLE, 8'h00);
		chk("enable", q, 8'ha5);
		src.fire(8'hff);
		wb(1'h0, OFF_FLAGS, 8'h00);
		chk("flags", q, LATCHED_MASK | 8'h10);
		chk("irq", {7'h0, irq}, 8'h00);
		wb(1'h1, OFF_FLAGS, 8'hff);
		src.bufs(1'h1, 1'h0);
		wb(1'h0, OFF_FLAGS, 8'h00);
		chk("flags", q, 8'h20);
		src.bufs(1'h0, 1'h0);
		for (int i = 0; i < SRC_N; i++)
			if (LATCHED_MASK[i])
			begin
				wb(1'h1, OFF_CORE_CTRL, 8'h80);
				wb(1'h1, OFF_ENABLE, 8'h01 << i);
				src.fire(8'h01 << i);
				@(negedge clk);
				chk("irq", {7'h0, irq}, 8'h00);
				wb(1'h1, OFF_CORE_CTRL, 8'hc0);
				chk("irq", {7'h0, irq}, 8'h01);
				wb(1'h1, OFF_FLAGS, 8'h01 << i);
				chk("irq", {7'h0, irq}, 8'h00);
				src.fire(8'h01 << i);
				@(negedge clk);
				chk("irq", {7'h0, irq}, 8'h01);
				wb(1'h1, OFF_ENABLE, ~(8'h01 << i));
				chk("irq", {7'h0, irq}, 8'h00);
				wb(1'h1, OFF_FLAGS, 8'hff);
			end
		wrap_up();
	end
endmodule
`default_nettype wire
